// ### logic/fls_pkg.sv
// Purpose: shared constants and types for the flash call sequencer
// Assumes: 32-bit parameter words, one 128-byte page latch
// Notes:   failure status words are built with fail_word
package fls_pkg;

	// register port offsets
	localparam logic [3:0]  ADDR_ARG     = 4'h0;
	localparam logic [3:0]  ADDR_REQ     = 4'h4;

	// request register layout
	localparam int          REQ_FLAG_BIT = 31;
	localparam logic [15:0] OP_LOAD      = 16'h0004;
	localparam logic [15:0] OP_WROW      = 16'h0005;
	localparam logic [15:0] OP_CLK       = 16'h0015;

	// first parameter word layout and keys
	localparam int          K1_LSB       = 0;
	localparam int          K2_LSB       = 8;
	localparam int          BADDR_LSB    = 16;
	localparam int          MACRO_LSB    = 24;
	localparam int          ROW_LSB      = 16;
	localparam logic [7:0]  KEY1         = 8'hb6;
	localparam logic [7:0]  KEY2_LOAD    = 8'hd7;
	localparam logic [7:0]  KEY2_WROW    = 8'hd8;
	localparam logic [7:0]  MACRO_MAX    = 8'h01;

	// parameter block offsets
	localparam logic [31:0] LEN_OFS      = 32'h0000_0004;
	localparam logic [31:0] DATA_OFS     = 32'h0000_0008;

	// page latch geometry
	localparam int          ROW_BYTES    = 128;
	localparam int          LAT_AW       = 7;
	localparam logic [7:0]  LAT_LAST     = 8'h7f;

	// oscillator setting needed by the charge pump
	localparam logic [7:0]  OSC_MHZ      = 8'h30;

	// status words
	localparam logic [31:0] ST_OK        = 32'ha000_0000;
	localparam logic [23:0] FAIL_HI      = 24'hf0_0000;
	localparam logic [7:0]  RSN_KEY      = 8'h01;
	localparam logic [7:0]  RSN_PUMP     = 8'h02;
	localparam logic [7:0]  RSN_OPC      = 8'h03;
	localparam logic [7:0]  RSN_PARAM    = 8'h04;
	localparam logic [7:0]  RSN_WPROT    = 8'h05;

	// register port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        we;
		logic        re;
	} fls_bus_s;

	// flash macro operations
	typedef enum logic {FOP_ERASE, FOP_PROG} fls_fop_e;

	// failure status word from a reason byte
	function automatic logic [31:0] fail_word(input logic [7:0] rsn);
		return {FAIL_HI, rsn};
	endfunction

endpackage

// ### logic/fls_page_latch.sv
// Purpose: page latch buffer holding one row of data to program
// Assumes: single writer, single reader, same clock
// Notes:   a per-byte nonzero map gives the all-zero test in one cycle
`timescale 1ns/1ps
`default_nettype none
module fls_page_latch #(
	parameter int BYTES = fls_pkg::ROW_BYTES,
	parameter int AW    = fls_pkg::LAT_AW
) (
	// clock and reset
	input  wire logic          mclk,
	input  wire logic          srst,
	input  wire logic          clk_en,
	// write side
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [7:0]    wr_data,
	input  wire logic          clear,
	// read side, data one cycle later
	input  wire logic [AW-1:0] rd_addr,
	output logic      [7:0]    rd_data,
	output logic               all_zero
);
	import fls_pkg::*;

	logic [7:0]       mem [BYTES];      // latch bytes
	logic [7:0]       next_mem [BYTES];
	logic [BYTES-1:0] nz;               // byte holds a nonzero value
	logic [BYTES-1:0] next_nz;
	logic [7:0]       next_rd_data;

	assign all_zero = ~|nz;

	// clear wins over a write in the same cycle
	always_comb begin
		next_mem     = mem;
		next_nz      = nz;
		next_rd_data = mem[rd_addr];
		if (clear) begin
			next_mem = '{default: 8'h00};
			next_nz  = '0;
		end else if (wr_en) begin
			next_mem[wr_addr] = wr_data;
			next_nz[wr_addr]  = |wr_data;
		end
	end

	// contents survive between calls, only reset or clear empties them
	always_ff @(posedge mclk) begin
		if (srst) begin
			mem     <= '{default: 8'h00};
			nz      <= '0;
			rd_data <= 8'h00;
		end else if (clk_en) begin
			mem     <= next_mem;
			nz      <= next_nz;
			rd_data <= next_rd_data;
		end
	end

endmodule
`default_nettype wire

// ### logic/fls_flash_port.sv
// Purpose: drives one erase or program request to the flash macro
// Assumes: flash_done is a one-cycle pulse from same-clock logic
// Notes:   request levels stand until the macro answers
`timescale 1ns/1ps
`default_nettype none
module fls_flash_port (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                srst,
	input  wire logic                clk_en,
	// sequencer side
	input  wire logic                start,
	input  wire fls_pkg::fls_fop_e   op,
	input  wire logic [15:0]         row,
	input  wire logic [7:0]          macro,
	output logic                     op_done,
	// flash macro side
	output logic                     flash_erase,
	output logic                     flash_prog,
	output logic      [15:0]         flash_row,
	output logic      [7:0]          flash_macro,
	input  wire logic                flash_done
);
	import fls_pkg::*;

	logic        next_erase;
	logic        next_prog;
	logic [15:0] next_row;
	logic [7:0]  next_macro;
	logic        next_done;

	// a start while a request stands is ignored
	always_comb begin
		next_erase = flash_erase;
		next_prog  = flash_prog;
		next_row   = flash_row;
		next_macro = flash_macro;
		next_done  = 1'b0;
		if (flash_erase || flash_prog) begin
			if (flash_done) begin
				next_erase = 1'b0;
				next_prog  = 1'b0;
				next_done  = 1'b1;
			end
		end else if (start) begin
			next_erase = (op == FOP_ERASE);
			next_prog  = (op == FOP_PROG);
			next_row   = row;
			next_macro = macro;
		end
	end

	// register every pin
	always_ff @(posedge mclk) begin
		if (srst) begin
			flash_erase <= 1'b0;
			flash_prog  <= 1'b0;
			flash_row   <= 16'h0000;
			flash_macro <= 8'h00;
			op_done     <= 1'b0;
		end else if (clk_en) begin
			flash_erase <= next_erase;
			flash_prog  <= next_prog;
			flash_row   <= next_row;
			flash_macro <= next_macro;
			op_done     <= next_done;
		end
	end

endmodule
`default_nettype wire

// ### logic/fls_sequencer.sv
// Purpose: flash call sequencer for clock setup, latch load and row write
// Assumes: parameter memory, clock controller and flash on mclk
// Notes:   registers frozen by software while a call runs
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01: clock call selects oscillator at 48 MHz
// R02: wrong pump clock fails row write untouched
// R03: load length one to 128 bytes
// R04: load starts at byte offset bits 23:16
// R05: latch persists until a row program
// R06: requester puts aligned parameter address first
// R07: keys b6 and d7 checked for load
// R08: bits 31:24 select flash macro
// R09: length word at offset four, minus one
// R10: data bytes from offset eight, in order
// R11: requester writes opcode four with flag
// R12: success shows a in bits 31:28
// R13: row write erases, then programs
// R14: all-zero latch skips programming
// R15: programming clears the page latch
// R16: protected rows are never modified
// R17: requester configures clock and loads first
// R18: row write keys b6, d8, row, opcode
// R19: failure status f00000 plus reason byte
// R20: flag cleared when call completes
module fls_sequencer (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                srst,
	input  wire logic                clk_en,
	// register port
	input  wire fls_pkg::fls_bus_s   bus,
	output logic      [31:0]         reg_rdata,
	// parameter memory read port
	output logic                     sram_rd,
	output logic      [31:0]         sram_addr,
	input  wire logic                sram_ack,
	input  wire logic [31:0]         sram_rdata,
	// clock controller
	output logic                     pump_sel_osc,
	output logic                     hf_sel_osc,
	output logic      [7:0]          osc_freq_cfg,
	input  wire logic                pump_from_osc,
	input  wire logic [7:0]          osc_mhz,
	// row protection lookup
	output logic      [15:0]         prot_row,
	input  wire logic                prot_hit,
	// flash macro
	output logic                     flash_erase,
	output logic                     flash_prog,
	output logic      [15:0]         flash_row,
	output logic      [7:0]          flash_macro,
	input  wire logic                flash_done,
	input  wire logic [6:0]          flash_lat_addr,
	output logic      [7:0]          flash_lat_data
);
	import fls_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE, S_KEY, S_LEN, S_DATA, S_PROT, S_ERASE, S_PROG
	} fls_state_e;

	fls_state_e  state;          // call sequencer state
	fls_state_e  next_state;
	logic [31:0] arg;            // syscall_argument
	logic [31:0] next_arg;
	logic [31:0] req;            // syscall_request
	logic [31:0] next_req;
	logic [6:0]  offs;           // first latch byte
	logic [6:0]  next_offs;
	logic [6:0]  cnt;            // length minus one
	logic [6:0]  next_cnt;
	logic [6:0]  idx;            // byte being loaded
	logic [6:0]  next_idx;
	logic [7:0]  macro_sel;      // macro chosen by last load
	logic [7:0]  next_macro_sel;
	logic [15:0] row_sel;        // row of the running write
	logic [15:0] next_row_sel;
	logic        next_sram_rd;
	logic [31:0] next_sram_addr;
	logic        next_pump;
	logic        next_hf;
	logic [7:0]  next_freq;
	logic [15:0] next_prot_row;
	logic [31:0] next_rdata;

	// latch and flash port hookup
	logic        lat_we;
	logic [6:0]  lat_waddr;
	logic [7:0]  lat_wdata;
	logic        lat_clr;
	logic        lat_zero;
	logic        fp_start;
	fls_fop_e    fp_op;
	logic        fp_done;

	// decode of the request, the request write and the fetched first word
	logic [15:0] opc;
	logic        is_load;
	logic        key_ok;
	logic        go;

	// word holding data byte i, parameter block is word aligned
	function automatic logic [31:0] data_addr(input logic [31:0] base,
	                                          input logic [6:0] i);
		return base + DATA_OFS + {25'h0000000, i[6:2], 2'b00};
	endfunction

	// byte lane i of a fetched word, first byte in the low lane
	function automatic logic [7:0] lane(input logic [31:0] w, input logic [6:0] i);
		return w[{i[1:0], 3'b000} +: 8];
	endfunction

	assign opc     = req[15:0];
	assign is_load = (opc == OP_LOAD);
	assign go      = bus.we && (bus.addr == ADDR_REQ) && bus.wdata[REQ_FLAG_BIT]
	                 && (state == S_IDLE);
	// key pair depends on the call
	assign key_ok  = (sram_rdata[K1_LSB +: 8] == KEY1)                               // R07
	                 && (sram_rdata[K2_LSB +: 8] == (is_load ? KEY2_LOAD : KEY2_WROW)); // R18

	// call sequencing and register updates
	always_comb begin
		next_state     = state;
		next_arg       = arg;
		next_req       = req;
		next_offs      = offs;
		next_cnt       = cnt;
		next_idx       = idx;
		next_macro_sel = macro_sel;
		next_row_sel   = row_sel;
		next_sram_rd   = 1'b0;
		next_sram_addr = sram_addr;
		next_pump      = pump_sel_osc;
		next_hf        = hf_sel_osc;
		next_freq      = osc_freq_cfg;
		next_prot_row  = prot_row;
		lat_we         = 1'b0;
		lat_waddr      = offs + idx;                                   // R04
		lat_wdata      = lane(sram_rdata, idx);                        // R10
		lat_clr        = 1'b0;
		fp_start       = 1'b0;
		fp_op          = FOP_ERASE;
		// software writes land only while idle
		if (bus.we && state == S_IDLE) begin
			if (bus.addr == ADDR_ARG)
				next_arg = bus.wdata;
			if (bus.addr == ADDR_REQ)
				next_req = bus.wdata;
		end
		unique case (state)
			S_IDLE: begin
				if (go) begin
					if (bus.wdata[15:0] == OP_CLK) begin
						// pump and fast clock from the oscillator
						next_pump = 1'b1;                              // R01
						next_hf   = 1'b1;
						next_freq = OSC_MHZ;
						next_arg  = ST_OK;                             // R12
						next_req[REQ_FLAG_BIT] = 1'b0;                 // R20
					end else if (bus.wdata[15:0] == OP_LOAD || bus.wdata[15:0] == OP_WROW) begin
						// fetch key word at the argument address
						next_sram_rd   = 1'b1;
						next_sram_addr = arg;
						next_state     = S_KEY;
					end else begin
						next_arg = fail_word(RSN_OPC);                 // R19
						next_req[REQ_FLAG_BIT] = 1'b0;
					end
				end
			end
			S_KEY: begin
				if (sram_ack) begin
					if (!key_ok) begin
						next_arg   = fail_word(RSN_KEY);               // R07
						next_state = S_IDLE;
					end else if (is_load) begin
						// macro and start offset range checks
						if (sram_rdata[MACRO_LSB +: 8] > MACRO_MAX         // R08
						    || sram_rdata[BADDR_LSB +: 8] > LAT_LAST) begin
							next_arg   = fail_word(RSN_PARAM);
							next_state = S_IDLE;
						end else begin
							next_macro_sel = sram_rdata[MACRO_LSB +: 8];
							next_offs      = sram_rdata[BADDR_LSB +: 7];   // R04
							next_sram_rd   = 1'b1;
							next_sram_addr = arg + LEN_OFS;                // R09
							next_state     = S_LEN;
						end
					end else if (pump_from_osc && osc_mhz != OSC_MHZ) begin
						// flash is left alone on a bad pump clock
						next_arg   = fail_word(RSN_PUMP);              // R02
						next_state = S_IDLE;
					end else begin
						next_row_sel  = sram_rdata[ROW_LSB +: 16];     // R18
						next_prot_row = sram_rdata[ROW_LSB +: 16];
						next_state    = S_PROT;
					end
				end
			end
			S_LEN: begin
				if (sram_ack) begin
					// length must fit between offset and row end
					if (sram_rdata[7:0] > LAT_LAST                     // R03
					    || {1'b0, offs} + sram_rdata[7:0] > LAT_LAST) begin
						next_arg   = fail_word(RSN_PARAM);
						next_state = S_IDLE;
					end else begin
						next_cnt       = sram_rdata[6:0];              // R09
						next_idx       = 7'h00;
						next_sram_rd   = 1'b1;
						next_sram_addr = data_addr(arg, 7'h00);        // R10
						next_state     = S_DATA;
					end
				end
			end
			S_DATA: begin
				if (sram_ack) begin
					lat_we = 1'b1;                                     // R05
					if (idx == cnt) begin
						next_arg   = ST_OK;                            // R12
						next_state = S_IDLE;
					end else begin
						// one fetch per byte keeps the lane logic trivial
						next_idx       = idx + 7'h01;
						next_sram_rd   = 1'b1;
						next_sram_addr = data_addr(arg, idx + 7'h01);
					end
				end
			end
			S_PROT: begin
				// lookup answers in the same cycle that prot_row moved
				if (prot_hit) begin
					next_arg   = fail_word(RSN_WPROT);                 // R16
					next_state = S_IDLE;
				end else begin
					fp_start   = 1'b1;                                 // R13
					fp_op      = FOP_ERASE;
					next_state = S_ERASE;
				end
			end
			S_ERASE: begin
				if (fp_done) begin
					if (lat_zero) begin
						next_arg   = ST_OK;                            // R14
						next_state = S_IDLE;
					end else begin
						fp_start   = 1'b1;                             // R13
						fp_op      = FOP_PROG;
						next_state = S_PROG;
					end
				end
			end
			S_PROG: begin
				if (fp_done) begin
					lat_clr    = 1'b1;                                 // R15
					next_arg   = ST_OK;
					next_state = S_IDLE;
				end
			end
			// the one unused code falls back to idle
			default: next_state = S_IDLE;
		endcase
		// any return to idle ends the call
		if (state != S_IDLE && next_state == S_IDLE)
			next_req[REQ_FLAG_BIT] = 1'b0;                             // R20
	end

	// read data stand one cycle after the strobe, unmapped reads zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (bus.re) begin
			if (bus.addr == ADDR_ARG)
				next_rdata = arg;
			else if (bus.addr == ADDR_REQ)
				next_rdata = req;
		end
	end

	// sequencer state
	always_ff @(posedge mclk) begin
		if (srst) begin
			state        <= S_IDLE;
			arg          <= 32'h0000_0000;
			req          <= 32'h0000_0000;
			offs         <= 7'h00;
			cnt          <= 7'h00;
			idx          <= 7'h00;
			macro_sel    <= 8'h00;
			row_sel      <= 16'h0000;
			sram_rd      <= 1'b0;
			sram_addr    <= 32'h0000_0000;
			pump_sel_osc <= 1'b0;
			hf_sel_osc   <= 1'b0;
			osc_freq_cfg <= 8'h00;
			prot_row     <= 16'h0000;
			reg_rdata    <= 32'h0000_0000;
		end else if (clk_en) begin
			state        <= next_state;
			arg          <= next_arg;
			req          <= next_req;
			offs         <= next_offs;
			cnt          <= next_cnt;
			idx          <= next_idx;
			macro_sel    <= next_macro_sel;
			row_sel      <= next_row_sel;
			sram_rd      <= next_sram_rd;
			sram_addr    <= next_sram_addr;
			pump_sel_osc <= next_pump;
			hf_sel_osc   <= next_hf;
			osc_freq_cfg <= next_freq;
			prot_row     <= next_prot_row;
			reg_rdata    <= next_rdata;
		end
	end

	// page latch buffer
	fls_page_latch u_latch (
		.mclk     (mclk),
		.srst     (srst),
		.clk_en   (clk_en),
		.wr_en    (lat_we),
		.wr_addr  (lat_waddr),
		.wr_data  (lat_wdata),
		.clear    (lat_clr),
		.rd_addr  (flash_lat_addr),
		.rd_data  (flash_lat_data),
		.all_zero (lat_zero)
	);

	// flash macro request driver
	fls_flash_port u_fport (
		.mclk        (mclk),
		.srst        (srst),
		.clk_en      (clk_en),
		.start       (fp_start),
		.op          (fp_op),
		.row         (row_sel),
		.macro       (macro_sel),
		.op_done     (fp_done),
		.flash_erase (flash_erase),
		.flash_prog  (flash_prog),
		.flash_row   (flash_row),
		.flash_macro (flash_macro),
		.flash_done  (flash_done)
	);

	// checks, frozen cycles excluded
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst || !clk_en);

	sequence s_erase_end;
		state == S_ERASE && fp_done;
	endsequence

	sequence s_prog_start;
		fp_start && fp_op == FOP_PROG;
	endsequence

	AST_CLK_CFG: assert property (go && bus.wdata[15:0] == OP_CLK |=> // R01
		pump_sel_osc && hf_sel_osc && osc_freq_cfg == OSC_MHZ && !req[REQ_FLAG_BIT])
		else $error("clock call did not select the oscillator");
	AST_PUMP_BAD: assert property (state == S_KEY && sram_ack && key_ok && !is_load // R02
		&& pump_from_osc && osc_mhz != OSC_MHZ |=> arg == fail_word(RSN_PUMP)
		&& state == S_IDLE ##1 !flash_erase)
		else $error("bad pump clock did not fail the row write");
	AST_KEY_BAD: assert property (state == S_KEY && sram_ack && !key_ok |=> // R07
		arg == fail_word(RSN_KEY) && state == S_IDLE)
		else $error("wrong key accepted");
	AST_MACRO_BAD: assert property (state == S_KEY && sram_ack && key_ok && is_load // R08
		&& sram_rdata[MACRO_LSB +: 8] > MACRO_MAX |=> arg == fail_word(RSN_PARAM))
		else $error("bad macro select accepted");
	AST_ERASE_FIRST: assert property (s_prog_start |-> s_erase_end) // R13
		else $error("program started without a finished erase");
	AST_SKIP_ZERO: assert property (s_erase_end ##0 lat_zero |-> !fp_start // R14
		##1 arg == ST_OK ##1 !flash_prog)
		else $error("all-zero latch was programmed");
	AST_LAT_CLEAR: assert property (state == S_PROG && fp_done |=> lat_zero // R15
		&& arg[31:28] == ST_OK[31:28])
		else $error("latch not cleared after program");
	AST_PROT: assert property (state == S_PROT && prot_hit |-> !fp_start // R16
		##1 arg == fail_word(RSN_WPROT) ##1 !flash_erase[*2])
		else $error("protected row was touched");
	AST_FLAG_CLR: assert property (state != S_IDLE ##1 state == S_IDLE |-> // R20
		!req[REQ_FLAG_BIT] && (arg[31:28] == ST_OK[31:28] || arg[31:8] == FAIL_HI))
		else $error("call ended without clearing flag and status");

endmodule
`default_nettype wire

// ### dv/fls_env_model.sv
// Purpose: parameter memory and flash macro beside the sequencer
// Assumes: same clock as the sequencer, bench fills mem
// Notes:   read data not being answered shows its inverse
`timescale 1ns/1ps
`default_nettype none
module fls_env_model (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// parameter memory
	input  wire logic        sram_rd,
	input  wire logic [31:0] sram_addr,
	output logic             sram_ack,
	output logic      [31:0] sram_rdata,
	// flash macro
	input  wire logic        flash_erase,
	input  wire logic        flash_prog,
	input  wire logic [15:0] flash_row,
	input  wire logic [7:0]  flash_macro,
	output logic             flash_done,
	output logic      [6:0]  flash_lat_addr,
	input  wire logic [7:0]  flash_lat_data
);
	logic [31:0] mem [0:255]; // parameter words
	logic [7:0]  img [0:127]; // last programmed row
	logic [9:0]  sa;          // pending read address
	logic [1:0]  sw;          // wait count
	logic [1:0]  rot;         // rotating latency, prompt and slow
	logic [7:0]  cnt;         // cycles into a flash request
	logic [15:0] erow;        // row of last erase
	logic [7:0]  emac;        // macro of last erase
	int          n_erase;
	int          n_prog;
	// memory answers one to three cycles after the request
	always @(posedge mclk) begin
		sram_ack <= 1'b0;
		sram_rdata <= ~sram_rdata;
		rot <= rot + 2'h1;
		if (srst) begin
			sw <= 2'h0;
			rot <= 2'h0;
			sram_rdata <= 32'h0;
		end else if (sram_rd) begin
			sa <= sram_addr[9:0];
			sw <= (rot == 2'h3) ? 2'h1 : rot + 2'h1;
		end else if (sw != 2'h0) begin
			sw <= sw - 2'h1;
			if (sw == 2'h1) begin
				sram_ack <= 1'b1;
				sram_rdata <= mem[sa[9:2]];
			end
		end
	end
	// program reads the whole latch before answering
	always @(posedge mclk) begin
		flash_done <= 1'b0;
		if (srst) begin
			cnt <= 8'h0;
			flash_lat_addr <= 7'h0;
			n_erase <= 0;
			n_prog <= 0;
		end else if ((flash_erase | flash_prog) && !flash_done) begin
			cnt <= cnt + 8'h1;
			flash_lat_addr <= cnt[6:0];
			if (flash_prog && cnt >= 8'h2 && cnt <= 8'h81) begin
				img[cnt[6:0] - 7'h2] <= flash_lat_data;
			end
			if (cnt == (flash_prog ? 8'h82 : 8'h3)) begin
				flash_done <= 1'b1;
				cnt <= 8'h0;
				erow <= flash_row;
				emac <= flash_macro;
				if (flash_prog) n_prog <= n_prog + 1;
				else n_erase <= n_erase + 1;
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/flash_latch_load_and_row_write_tb.sv
// Purpose: self-checking bench for the flash call sequencer
// Assumes: memory and flash model beside the sequencer
// Notes:   expected latch image kept here, seed fixed
`timescale 1ns/1ps
`default_nettype none
module flash_latch_load_and_row_write_tb;
	import fls_pkg::*;
	localparam logic [31:0] OK = 32'ha000_0000;
	logic        mclk, srst, clk_en, sram_rd, sram_ack, pump_sel_osc, hf_sel_osc;
	logic        pump_from_osc, prot_hit, flash_erase, flash_prog, flash_done;
	fls_bus_s    bus;
	logic [31:0] reg_rdata, sram_addr, sram_rdata;
	logic [7:0]  osc_freq_cfg, osc_mhz, flash_macro, flash_lat_data, last_mac;
	logic [15:0] prot_row, flash_row;
	logic [6:0]  flash_lat_addr;
	logic [7:0]  exp_lat [0:127]; // expected latch
	int          n_errors, checked;
	assign clk_en = 1'b1;
	assign prot_hit = (prot_row == 16'h0033); // only row 0x33 protected
	initial mclk = 1'b0;
	always #5 mclk = ~mclk;
	fls_sequencer uut (.mclk(mclk), .srst(srst), .clk_en(clk_en), .bus(bus),
		.reg_rdata(reg_rdata), .sram_rd(sram_rd), .sram_addr(sram_addr), .sram_ack(sram_ack),
		.sram_rdata(sram_rdata), .pump_sel_osc(pump_sel_osc), .hf_sel_osc(hf_sel_osc),
		.osc_freq_cfg(osc_freq_cfg), .pump_from_osc(pump_from_osc), .osc_mhz(osc_mhz),
		.prot_row(prot_row), .prot_hit(prot_hit), .flash_erase(flash_erase),
		.flash_prog(flash_prog), .flash_row(flash_row), .flash_macro(flash_macro),
		.flash_done(flash_done), .flash_lat_addr(flash_lat_addr),
		.flash_lat_data(flash_lat_data));
	fls_env_model env (.mclk(mclk), .srst(srst), .sram_rd(sram_rd), .sram_addr(sram_addr),
		.sram_ack(sram_ack), .sram_rdata(sram_rdata), .flash_erase(flash_erase),
		.flash_prog(flash_prog), .flash_row(flash_row), .flash_macro(flash_macro),
		.flash_done(flash_done), .flash_lat_addr(flash_lat_addr),
		.flash_lat_data(flash_lat_data));
	// failure status expected for a reason byte
	function automatic logic [31:0] fail(input logic [7:0] rsn);
		return {24'hf0_0000, rsn};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		bus.we <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk);
		bus.re <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// start a call, poll the flag under a bound, fetch status
	task automatic call(input logic [15:0] op, input logic [31:0] arg, output logic [31:0] st);
		logic [31:0] r;
		int n;
		wr(ADDR_ARG, arg);
		wr(ADDR_REQ, {16'h8000, op});
		n = 0;
		r = 32'hffff_ffff;
		while (r[31] !== 1'b0 && n < 2000) begin
			rd(ADDR_REQ, r);
			n++;
		end
		chk({31'h0, r[31]}, 32'h0);
		rd(ADDR_ARG, st);
	endtask
	task automatic load(input logic [7:0] key, input logic [7:0] mac, input int off,
		input int len, input logic [31:0] want);
		logic [31:0] st;
		logic [7:0] b;
		env.mem[0] = {mac, 8'(off), key, 8'hb6};
		env.mem[1] = {24'($urandom), 8'(len - 1)}; // upper bits are noise
		for (int i = 0; i < len; i++) begin
			b = 8'($urandom);
			env.mem[2 + i / 4][8 * (i % 4) +: 8] = b;
			if (want === OK) exp_lat[off + i] = b;
		end
		if (want === OK) last_mac = mac;
		call(OP_LOAD, 32'h0, st);
		chk(st, want);
	endtask
	task automatic wrow(input logic [15:0] row, input logic [31:0] want);
		logic [31:0] st;
		int ne, np;
		logic nz;
		ne = env.n_erase;
		np = env.n_prog;
		nz = 1'b0;
		foreach (exp_lat[i]) nz |= (exp_lat[i] != 8'h0);
		env.mem[128] = {row, 8'hd8, 8'hb6};
		call(OP_WROW, 32'h200, st);
		chk(st, want);
		if (want !== OK) begin
			chk(env.n_erase - ne, 0);
		end else begin
			chk(env.n_erase - ne, 1);
			chk({env.emac, env.erow}, {last_mac, row});
			chk(env.n_prog - np, {31'h0, nz});
			if (nz) begin
				foreach (exp_lat[i]) chk({24'h0, env.img[i]}, {24'h0, exp_lat[i]});
				foreach (exp_lat[i]) exp_lat[i] = 8'h0;
			end
		end
	endtask
	task automatic final_report;
		if (n_errors == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		logic [31:0] st;
		int off, len;
		bus = '0;
		srst = 1'b1;
		pump_from_osc = 1'b1;
		osc_mhz = 8'h30;
		last_mac = 8'h0;
		n_errors = 0;
		checked = 0;
		foreach (exp_lat[i]) exp_lat[i] = 8'h0;
		void'($urandom(44803));
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		call(OP_CLK, 32'h0, st);
		chk(st, OK);
		chk({22'h0, pump_sel_osc, hf_sel_osc, osc_freq_cfg}, {22'h0, 2'b11, 8'h30});
		call(16'h0007, 32'h0, st);
		chk(st, fail(8'h03));
		// full row, last byte alone, no load, random pieces
		for (int it = 0; it < 6; it++) begin
			for (int k = 0; k < ((it == 2) ? 0 : 1 + it % 2); k++) begin
				off = (it == 0) ? 0 : (it == 1) ? 127 : $urandom_range(127);
				len = (it == 0) ? 128 : (it == 1) ? 1 : $urandom_range(128 - off, 1);
				load(8'hd7, 8'($urandom_range(1)), off, len, OK);
			end
			wrow((it == 0) ? 16'hffff : 16'($urandom_range(50)), OK);
		end
		load(8'hd8, 8'h0, 0, 4, fail(8'h01));
		load(8'hd7, 8'h2, 0, 4, fail(8'h04));
		load(8'hd7, 8'h0, 127, 2, fail(8'h04));
		load(8'hd7, 8'h0, 128, 1, fail(8'h04));
		load(8'hd7, 8'h0, 0, 129, fail(8'h04));
		load(8'hd7, 8'h1, 5, 3, OK);
		@(posedge mclk);
		osc_mhz <= 8'h2f;
		wrow(16'h0010, fail(8'h02));
		@(posedge mclk);
		pump_from_osc <= 1'b0;
		wrow(16'h0010, OK);
		@(posedge mclk);
		pump_from_osc <= 1'b1;
		osc_mhz <= 8'h30;
		wrow(16'h0033, fail(8'h05));
		wrow(16'h0011, OK);
		env.mem[128] = {16'h0011, 8'hd7, 8'hb6};
		call(OP_WROW, 32'h200, st);
		chk(st, fail(8'h01));
		final_report;
	end
	initial begin
		#800000;
		n_errors++;
		final_report;
	end
endmodule
`default_nettype wire
